// ---- sgcb_monitor.sv ----
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module sgcb_monitor (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        stat_valid,
  input wire logic [4:0]  stat_fwd_ports,
  input wire logic        stat_mac_mcast,
  input wire logic        stat_remove,
  input wire logic [4:0]  port_learn_dis,
  input wire logic [4:0]  port_link,
  input wire logic [4:0]  an_tx_pause,
  input wire logic [4:0]  an_rx_pause,
  input wire logic [4:0]  tx_fc_en,
  input wire logic [4:0]  rx_fc_en,
  input wire logic        age_flush_learned,
  input wire logic        frm_valid,
  input wire logic [47:0] frm_da,
  input wire logic [15:0] frm_type_len,
  input wire logic [15:0] frm_opcode,
  input wire logic        frm_drop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  rd_unmapped_a: assert property ($past(reg_rd) &&
    !($past(reg_addr) inside {8'h02, 8'h03}) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  tx_fc_gate_a: assert property ((tx_fc_en & ~$past(an_tx_pause)) == 5'h00)
    else $error("transmit flow control without negotiation");
  rx_fc_gate_a: assert property ((rx_fc_en & ~$past(an_rx_pause)) == 5'h00)
    else $error("receive flow control without negotiation");
  link_loss_flush_a: assert property (
    (|($past(port_link) & ~port_link)) |=> age_flush_learned)
    else $error("no learned flush after link loss");
  flush_cause_a: assert property (
    age_flush_learned |-> |($past(port_link, 2) & ~$past(port_link)))
    else $error("learned flush without link loss");
  genuine_pause_a: assert property (
    frm_valid && frm_type_len == 16'h8808 && frm_opcode == 16'h0001
    && frm_da == sgcb_pkg::PAUSE_DA |=> frm_drop) else $error("pause frame kept");
  drop_cause_a: assert property (frm_drop |-> $past(frm_valid))
    else $error("drop without a frame");
  purge_match_a: assert property (stat_remove |-> $past(stat_valid &&
    $onehot(stat_fwd_ports) && !stat_mac_mcast && (stat_fwd_ports & port_learn_dis) != 5'h00))
    else $error("removed entry does not match");
endmodule

bind sgcb_top sgcb_monitor u_mon (.clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata, .stat_valid,
  .stat_fwd_ports, .stat_mac_mcast, .stat_remove, .port_learn_dis, .port_link, .an_tx_pause,
  .an_rx_pause, .tx_fc_en, .rx_fc_en, .age_flush_learned, .frm_valid, .frm_da, .frm_type_len,
  .frm_opcode, .frm_drop);

// ---- sgcb_pkg.sv ----
package sgcb_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_GCTL_ZERO = 8'h02;
  localparam logic [7:0] ADDR_GCTL_ONE  = 8'h03;

  // Global control zero field positions
  localparam int GC0_PURGE_BIT   = 4;
  localparam int GC0_RSVD3_BIT   = 3;
  localparam int GC0_RSVD2_BIT   = 2;
  localparam int GC0_PDROP_BIT   = 1;
  localparam int GC0_LCAGE_BIT   = 0;

  // Global control one field positions
  localparam int GC1_JUMBO_BIT   = 6;
  localparam int GC1_TXPD_BIT    = 5;
  localparam int GC1_RXPD_BIT    = 4;
  localparam int GC1_LCHK_BIT    = 3;
  localparam int GC1_AGE_BIT     = 2;
  localparam int GC1_FAGE_BIT    = 1;
  localparam int GC1_ABO_BIT     = 0;

  // Reset values of the writable fields
  localparam logic [4:0] GC0_RESET = 5'h0C;
  localparam logic [6:0] GC1_RESET = 7'h04;

  // ****************************************************************
  // Frame constants
  // ****************************************************************
  localparam logic [15:0] PAUSE_ETYPE   = 16'h8808;
  localparam logic [47:0] PAUSE_DA      = 48'h0180C2000001;
  localparam logic [15:0] PAUSE_OPCODE  = 16'h0001;
  localparam logic [15:0] LEN_LIMIT     = 16'h05DC;
  localparam logic [11:0] STD_MAX_LEN   = 12'h600;
  localparam logic [11:0] JUMBO_MAX_LEN = 12'h800;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int  CLK_MHZ        = 200;
  localparam int  FAST_AGE_US    = 800;
  localparam int  NORM_AGE_S     = 300;
  // Cycle counts: exact products of time and clock rate
  localparam longint FAST_AGE_CYC = longint'(FAST_AGE_US) * CLK_MHZ;
  localparam longint NORM_AGE_CYC = longint'(NORM_AGE_S) * 1000000 * CLK_MHZ;

  // Static table
  localparam int STAT_ENTRIES = 32;
  localparam int STAT_IDX_W   = 5;
  localparam int NPORTS       = 5;

  typedef enum logic [1:0] {
    SGCB_IDLE  = 2'b00,
    SGCB_SCAN  = 2'b01,
    SGCB_DONE  = 2'b11
  } sgcb_purge_t;

endpackage

// ---- sgcb_top.sv ----
// Overview of operation
// - Writing 1 to the static purge bit removes every matched static entry, then the bit clears itself.
// - An entry matches when it forwards to exactly one port, is unicast, and that port does not learn.
// - With pause drop select at 1, frames with type 0x8808 or destination 01-80-C2-00-00-01 are dropped.
// - With pause drop select at 0, only genuine flow control frames are dropped as pause frames.
// - With link change aging set, a link loss starts one fast age cycle, then normal aging resumes.
// - Any port losing its link ages out all learned addresses.
// - Frames over 1536 bytes and up to 2KB are accepted only while the 2KB support bit is 1, which resets to 0.
// - Transmit pause disable at 1 forces transmit flow control off, else follows autonegotiation.
// - Receive pause disable at 1 forces receive flow control off, else follows autonegotiation.
// - Both pause disable bits take their reset value from one strap, then are written separately.
// - With length checking on, frames with length below 1500 that disagrees with the real length drop.
// - The aging enable bit switches aging on or off and resets to 1.
// - The fast age bit makes the table age with the 800 us period.
// - The aggressive back-off bit selects a non-standard half-duplex back-off and resets to 0.
// - The first global control register sits at address 0x02.
`timescale 1ns/1ps
module sgcb_top #(
  parameter longint FAST_AGE_CYCLES = sgcb_pkg::FAST_AGE_CYC,
  parameter longint NORM_AGE_CYCLES = sgcb_pkg::NORM_AGE_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Strap for pause disable defaults
  input  wire logic        pause_dis_strap,
  // Static table access (one entry per cycle)
  output logic      [4:0]  stat_idx,
  input  wire logic        stat_valid,
  input  wire logic [4:0]  stat_fwd_ports,
  input  wire logic        stat_mac_mcast,
  output logic             stat_remove,
  input  wire logic [4:0]  port_learn_dis,
  // Link state and autonegotiation
  input  wire logic [4:0]  port_link,
  input  wire logic [4:0]  an_tx_pause,
  input  wire logic [4:0]  an_rx_pause,
  output logic      [4:0]  tx_fc_en,
  output logic      [4:0]  rx_fc_en,
  // Aging controls
  output logic             age_tick,
  output logic             age_flush_learned,
  // Frame check, one header presented per cycle
  input  wire logic        frm_valid,
  input  wire logic [47:0] frm_da,
  input  wire logic [15:0] frm_type_len,
  input  wire logic [15:0] frm_opcode,
  input  wire logic [11:0] frm_length,
  input  wire logic [11:0] frm_payload_len,
  output logic             frm_drop,
  // Mode outputs to the MACs
  output logic             aggr_backoff,
  output logic             jumbo_en,
  output logic             len_check_en
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [4:0]          gc0;
    logic [6:0]          gc1;
    logic                strap_done;
    sgcb_pkg::sgcb_purge_t purge_st;
    logic [4:0]          idx;
    logic                remove;
    logic [4:0]          link_prev;
    logic                fast_once;
    logic [39:0]         age_cnt;
    logic                tick;
    logic                flush_l;
    logic [7:0]          rdata;
    logic                drop;
    logic [4:0]          tx_fc;
    logic [4:0]          rx_fc;
  } sgcb_state_t;

  sgcb_state_t s_q, s_d;

  logic       match;
  logic       one_port;
  logic       port_nolearn;
  logic [4:0] link_lost;
  logic       fast_mode;
  logic [39:0] age_limit;
  logic       pause_frm;

  always_comb begin
    one_port     = (stat_fwd_ports != 5'h00) &&
                   ((stat_fwd_ports & (stat_fwd_ports - 5'h01)) == 5'h00);
    port_nolearn = |(stat_fwd_ports & port_learn_dis);
    match        = stat_valid && one_port && !stat_mac_mcast && port_nolearn;
    link_lost    = s_q.link_prev & ~port_link;
    fast_mode    = s_q.gc1[sgcb_pkg::GC1_FAGE_BIT] || s_q.fast_once;
    age_limit    = fast_mode ? FAST_AGE_CYCLES[39:0] : NORM_AGE_CYCLES[39:0];
    if (s_q.gc0[sgcb_pkg::GC0_PDROP_BIT]) begin
      pause_frm = (frm_type_len == sgcb_pkg::PAUSE_ETYPE) ||
                  (frm_da == sgcb_pkg::PAUSE_DA);
    end else begin
      pause_frm = (frm_type_len == sgcb_pkg::PAUSE_ETYPE) &&
                  (frm_da == sgcb_pkg::PAUSE_DA) &&
                  (frm_opcode == sgcb_pkg::PAUSE_OPCODE);
    end
  end

  always_comb begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    s_d.remove = 1'b0;
    s_d.tick  = 1'b0;
    s_d.flush_l = 1'b0;
    s_d.link_prev = port_link;

    // ****************************************************************
    // Strap capture after reset release
    // ****************************************************************
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.gc1[sgcb_pkg::GC1_TXPD_BIT] = pause_dis_strap;
      s_d.gc1[sgcb_pkg::GC1_RXPD_BIT] = pause_dis_strap;
    end

    // ****************************************************************
    // Register writes and reads
    // ****************************************************************
    if (reg_wr && reg_addr == sgcb_pkg::ADDR_GCTL_ZERO) begin
      s_d.gc0[sgcb_pkg::GC0_PDROP_BIT] = reg_wdata[sgcb_pkg::GC0_PDROP_BIT];
      s_d.gc0[sgcb_pkg::GC0_LCAGE_BIT] = reg_wdata[sgcb_pkg::GC0_LCAGE_BIT];
      // Purge cannot restart mid scan; software waits for it to clear
      if (reg_wdata[sgcb_pkg::GC0_PURGE_BIT] && s_q.purge_st == sgcb_pkg::SGCB_IDLE) begin
        s_d.gc0[sgcb_pkg::GC0_PURGE_BIT] = 1'b1;
        s_d.purge_st = sgcb_pkg::SGCB_SCAN;
        s_d.idx      = 5'h00;
      end
    end
    if (reg_wr && reg_addr == sgcb_pkg::ADDR_GCTL_ONE) begin
      s_d.gc1 = reg_wdata[6:0];
    end
    if (reg_rd) begin
      if (reg_addr == sgcb_pkg::ADDR_GCTL_ZERO) begin
        s_d.rdata = {3'h0, s_q.gc0};
      end else if (reg_addr == sgcb_pkg::ADDR_GCTL_ONE) begin
        s_d.rdata = {1'b0, s_q.gc1};
      end
    end

    // ****************************************************************
    // Static table purge walk
    // ****************************************************************
    unique case (s_q.purge_st)
      sgcb_pkg::SGCB_IDLE: begin
      end
      sgcb_pkg::SGCB_SCAN: begin
        s_d.remove = match;
        s_d.idx    = 5'(s_q.idx + 5'h01);
        if (s_q.idx == 5'(sgcb_pkg::STAT_ENTRIES - 1)) begin
          s_d.purge_st = sgcb_pkg::SGCB_DONE;
        end
      end
      sgcb_pkg::SGCB_DONE: begin
        s_d.gc0[sgcb_pkg::GC0_PURGE_BIT] = 1'b0;
        s_d.purge_st = sgcb_pkg::SGCB_IDLE;
      end
      default: s_d.purge_st = sgcb_pkg::SGCB_IDLE;
    endcase

    // ****************************************************************
    // Aging
    // ****************************************************************
    if (|link_lost) begin
      s_d.flush_l = 1'b1;
      if (s_q.gc0[sgcb_pkg::GC0_LCAGE_BIT]) begin
        s_d.fast_once = 1'b1;
        s_d.age_cnt   = 40'h0;
      end
    end else if (s_q.gc1[sgcb_pkg::GC1_AGE_BIT]) begin
      if (s_q.age_cnt + 40'h1 >= age_limit) begin
        s_d.age_cnt   = 40'h0;
        s_d.tick      = 1'b1;
        s_d.fast_once = 1'b0;
      end else begin
        s_d.age_cnt = s_q.age_cnt + 40'h1;
      end
    end

    // ****************************************************************
    // Frame filter and flow control
    // ****************************************************************
    s_d.drop = frm_valid && (pause_frm ||
      (s_q.gc1[sgcb_pkg::GC1_LCHK_BIT] && frm_type_len < sgcb_pkg::LEN_LIMIT &&
       frm_type_len[11:0] != frm_payload_len) ||
      (frm_length > (s_q.gc1[sgcb_pkg::GC1_JUMBO_BIT] ?
        sgcb_pkg::JUMBO_MAX_LEN : sgcb_pkg::STD_MAX_LEN)));
    s_d.tx_fc = s_q.gc1[sgcb_pkg::GC1_TXPD_BIT] ? 5'h00 : an_tx_pause;
    s_d.rx_fc = s_q.gc1[sgcb_pkg::GC1_RXPD_BIT] ? 5'h00 : an_rx_pause;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q          <= '0;
      s_q.gc0      <= sgcb_pkg::GC0_RESET;
      s_q.gc1      <= sgcb_pkg::GC1_RESET;
      s_q.purge_st <= sgcb_pkg::SGCB_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata         = s_q.rdata;
  assign stat_idx          = s_q.idx;
  assign stat_remove       = s_q.remove;
  assign tx_fc_en          = s_q.tx_fc;
  assign rx_fc_en          = s_q.rx_fc;
  assign age_tick          = s_q.tick;
  assign age_flush_learned = s_q.flush_l;
  assign frm_drop          = s_q.drop;
  assign aggr_backoff      = s_q.gc1[sgcb_pkg::GC1_ABO_BIT];
  assign jumbo_en          = s_q.gc1[sgcb_pkg::GC1_JUMBO_BIT];
  assign len_check_en      = s_q.gc1[sgcb_pkg::GC1_LCHK_BIT];

endmodule

// ---- sgcb_top_tb.sv ----
`timescale 1ns/1ps
// ****************************************
// Register and frame check bench
// ****************************************
module sgcb_top_tb;
  logic        clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, pause_dis_strap = 1, frm_valid = 0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [4:0]  stat_idx, stat_fwd_ports, tx_fc_en, rx_fc_en, port_link = 5'h1F;
  logic [4:0]  port_learn_dis = 5'h04, an_tx_pause = 5'h1F, an_rx_pause = 5'h1F;
  logic        stat_valid, stat_mac_mcast, stat_remove, age_tick, age_flush_learned, frm_drop;
  logic        aggr_backoff, jumbo_en, len_check_en;
  logic [47:0] frm_da = 48'h0;
  logic [15:0] frm_type_len = 16'h0, frm_opcode = 16'h0001;
  logic [11:0] frm_length = 12'h0, frm_payload_len = 12'h0;
  int          failures = 0, total_checks = 0, ticks = 0, removes = 0, flushes = 0;
  sgcb_top #(.FAST_AGE_CYCLES(20), .NORM_AGE_CYCLES(50)) u_dut (.clk, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pause_dis_strap, .stat_idx, .stat_valid,
    .stat_fwd_ports, .stat_mac_mcast, .stat_remove, .port_learn_dis, .port_link, .an_tx_pause,
    .an_rx_pause, .tx_fc_en, .rx_fc_en, .age_tick, .age_flush_learned, .frm_valid, .frm_da,
    .frm_type_len, .frm_opcode, .frm_length, .frm_payload_len, .frm_drop, .aggr_backoff,
    .jumbo_en, .len_check_en);
  always #2.5 clk = ~clk;
  // Entries 3 and 12 match; 7 has two ports, 9 is multicast, the rest use a learning port
  always_comb begin
    stat_valid = 1'b1;
    stat_mac_mcast = (stat_idx == 5'h09);
    stat_fwd_ports = (stat_idx == 5'h07) ? 5'h0C :
      ((stat_idx inside {5'h03, 5'h09, 5'h0C}) ? 5'h04 : 5'h01);
  end
  always @(posedge clk) begin
    if (age_tick === 1'b1) ticks++;
    if (stat_remove === 1'b1) removes++;
    if (age_flush_learned === 1'b1) flushes++;
  end
  task results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rdc(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg", reg_rdata, exp);
  endtask
  // Opcode is 0001 except for one frame, so a frame is genuine pause when type and address agree
  task frm(logic [47:0] da, logic [15:0] tl, logic [11:0] len, logic [11:0] pl, logic exp);
    @(posedge clk);
    frm_valid <= 1'b1; frm_da <= da; frm_type_len <= tl; frm_length <= len;
    frm_payload_len <= pl;
    @(posedge clk);
    frm_valid <= 1'b0;
    #1 chk("drop", {7'h00, frm_drop}, {7'h00, exp});
  endtask
  task age(int n, int lo, int hi);
    #1 ticks = 0;
    repeat (n) @(posedge clk);
    #1 chk("ticks", 8'(ticks >= lo && ticks <= hi), 8'h01);
  endtask
  task fc(logic [4:0] tx, logic [4:0] rx);
    repeat (3) @(posedge clk);
    #1 chk("tx_fc", {3'h0, tx_fc_en}, {3'h0, tx});
    chk("rx_fc", {3'h0, rx_fc_en}, {3'h0, rx});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(8'h02, 8'h0C);
    rdc(8'h03, 8'h34);
    rdc(8'h05, 8'h00);
    fc(5'h00, 5'h00);
    // Partial negotiation results so the gating is seen per port
    an_tx_pause <= 5'h15;
    wr(8'h03, 8'h14);
    rdc(8'h03, 8'h14);
    fc(5'h15, 5'h00);
    an_rx_pause <= 5'h0A;
    wr(8'h03, 8'h24);
    fc(5'h00, 5'h0A);
    wr(8'h03, 8'hFF);
    rdc(8'h03, 8'h7F);
    chk("modes", {5'h0, jumbo_en, len_check_en, aggr_backoff}, 8'h07);
    wr(8'h03, 8'h0C);
    frm(sgcb_pkg::PAUSE_DA, 16'h8808, 12'h040, 12'h000, 1'b1);
    frm_opcode <= 16'h0000;
    frm(sgcb_pkg::PAUSE_DA, 16'h8808, 12'h040, 12'h000, 1'b0);
    frm_opcode <= 16'h0001;
    frm(48'h0A, 16'h8808, 12'h040, 12'h000, 1'b0);
    frm(sgcb_pkg::PAUSE_DA, 16'h0800, 12'h040, 12'h000, 1'b0);
    frm(48'h0A, 16'h0064, 12'h040, 12'h064, 1'b0);
    frm(48'h0A, 16'h0064, 12'h040, 12'h032, 1'b1);
    frm(48'h0A, 16'h0800, 12'h7D0, 12'h000, 1'b1);
    wr(8'h02, 8'h0E);
    rdc(8'h02, 8'h0E);
    frm(48'h0A, 16'h8808, 12'h040, 12'h000, 1'b1);
    frm(sgcb_pkg::PAUSE_DA, 16'h0800, 12'h040, 12'h000, 1'b1);
    wr(8'h03, 8'h44);
    frm(48'h0A, 16'h0800, 12'h7D0, 12'h000, 1'b0);
    frm(48'h0A, 16'h0064, 12'h040, 12'h032, 1'b0);
    age(300, 5, 6);
    wr(8'h03, 8'h46);
    age(300, 14, 15);
    wr(8'h03, 8'h40);
    age(300, 0, 0);
    wr(8'h03, 8'h44);
    wr(8'h02, 8'h0D);
    port_link <= 5'h1D;
    age(25, 1, 2);
    chk("flushes", 8'(flushes), 8'h01);
    wr(8'h02, 8'h1C);
    rdc(8'h02, 8'h1C);
    // Scan of 32 entries ends well inside this span; software waits it out
    repeat (40) @(posedge clk);
    rdc(8'h02, 8'h0C);
    chk("removes", 8'(removes), 8'h02);
    results();
  end
  initial begin
    #20000;
    failures++;
    results();
  end
endmodule
